//--- core/sgss_top.sv
/*
 servo gain set selector: picks before / after / after-2 gain sets,
 time constant use on each change, and the fine vibration gain.
 assumes status flags come from same-clock servo logic; only the
 gain-2 request pin is asynchronous.
*/
//
// Contract
// - gain source 5 with gain-2 source 2 selects by command sign.
// - ccw is positive regardless of travel direction setting.
// - stop switch to gain set 2 only in position modes.
// - positive command picks before set, negative picks after set.
// - position modes, zero command, in-position off: keep set.
// - zero command, in-position on: keep at 0, gain set 2 at 1.
// - entering velocity mode while on gain set 2 keeps it.
// - velocity mode zero speed command always keeps current set.
// - velocity to position while stopped, zsp on, stop 1: set 2.
// - speed source with signal gain-2: word5 bit 4 or pin decide.
// - gain-2 request active applies gain-2 vibration/model sets.
// - disable-at-switching: instant switch, filtered return.
// - disable-at-return: filtered switch, instant return.
// - fine vibration suppression only in position modes.
// - fine vibration suppression only in manual tuning mode.
// - enable field 0 disables, 1 enables fine suppression.
// - in-position rising edge switches to computed fine gain.
// - droop over range while driven restores original gain.
`timescale 1ns/10ps
module sgss_top #(
   parameter int CMD_W = 16,
   parameter int CTL_DIV = sgss_pkg::CTL_CYCLES
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [1:0] op_mode,
   input wire logic signed [CMD_W-1:0] cmd_pulse_freq,
   input wire logic signed [CMD_W-1:0] speed_cmd,
   input wire sgss_pkg::sgss_flags_t flags,
   input wire logic gain2_request_input,
   output logic [1:0] gain_sel,
   output logic tc_apply,
   output logic gain2_sets,
   output logic fine_vib_gain
);
   // {negative, zero} of a signed command
   function automatic logic [1:0] cmd_dir(
      input logic signed [CMD_W-1:0] v);
      cmd_dir = {v[CMD_W-1], (v == '0)};
   endfunction

   logic tick;
   logic g2_pin;
   sgss_pkg::sgss_cfg_t cfg_q;
   logic [15:0] word5_q;
   logic [31:0] rdata_q;
   logic [1:0] gain_q;
   logic [1:0] gain_d;
   logic tc_q;
   logic g2sets_q;
   logic fine_q;
   sgss_pkg::sgss_fv_state_t fv_q;
   sgss_pkg::sgss_fv_state_t fv_d;
   logic [1:0] mode_prev_q;
   logic zsp_prev_q;
   logic inp_prev_q;

   sgss_tick_div #(
      .DIV(CTL_DIV)
   ) u_div (
      .ref_clk(ref_clk),
      .srst(srst),
      .tick(tick)
   );

   sgss_sync2 #(
      .W(1)
   ) u_sync (
      .ref_clk(ref_clk),
      .srst(srst),
      .din(gain2_request_input),
      .dout(g2_pin)
   );

   // mode decode
   wire logic vel_mode = (op_mode == sgss_pkg::MODE_VEL);
   wire logic pos_mode = (op_mode == sgss_pkg::MODE_POS) ||
      (op_mode == sgss_pkg::MODE_PSN);
   wire logic from_vel = (mode_prev_q == sgss_pkg::MODE_VEL);

   // command sign: speed in velocity mode, pulse rate otherwise;
   // the raw sign is ccw-positive, the travel direction setting is
   // deliberately not applied here
   wire logic [1:0] pulse_dir = cmd_dir(cmd_pulse_freq);
   wire logic [1:0] speed_dir = cmd_dir(speed_cmd);
   wire logic [1:0] dir = vel_mode ? speed_dir : pulse_dir;
   wire logic cmd_neg = dir[1];
   wire logic cmd_zero = dir[0];
   wire logic cmd_pos = !cmd_neg && !cmd_zero;

   // selection modes
   wire logic dir_sel = (cfg_q.gain_switch_source_select ==
      sgss_pkg::GSRC_DIR) && (cfg_q.gain2_source_select ==
      sgss_pkg::G2SRC_SAME);
   wire logic sig_sel = (cfg_q.gain_switch_source_select ==
      sgss_pkg::GSRC_SPEED) && (cfg_q.gain2_source_select ==
      sgss_pkg::G2SRC_SIGNAL);
   wire logic stop_en = cfg_q.stop_gain2_switch_select;

   // gain-2 request from the controller word or the pin
   wire logic g2_req = word5_q[sgss_pkg::WORD5_G2_BIT] || g2_pin;

   // stop-time switch: only in position modes, either with
   // in-position on or just after leaving velocity mode stopped
   wire logic stop_g2 = pos_mode && stop_en && cmd_zero &&
      (flags.in_position_flag ||
      (from_vel && zsp_prev_q));

   // next set in direction mode
   wire logic [1:0] dir_gain = cmd_pos ? sgss_pkg::GAIN_BEFORE :
      cmd_neg ? sgss_pkg::GAIN_AFTER :
      stop_g2 ? sgss_pkg::GAIN_AFTER2 :
      gain_q;

   // next set in speed mode with signal gain-2; the gain-2 speed
   // threshold never enters here
   wire logic [1:0] sig_gain = g2_req ? sgss_pkg::GAIN_AFTER2 :
      flags.speed_cond_met ? sgss_pkg::GAIN_AFTER :
      sgss_pkg::GAIN_BEFORE;

   always_comb
   begin
      if (dir_sel)
      begin
         gain_d = dir_gain;
      end
      else if (sig_sel)
      begin
         gain_d = sig_gain;
      end
      else
      begin
         gain_d = sgss_pkg::GAIN_BEFORE;
      end
   end

   // time constant on a change: leaving the before set is a switch,
   // coming back to it is a return
   wire logic g_change = (gain_d != gain_q);
   wire logic g_return = (gain_d == sgss_pkg::GAIN_BEFORE);
   wire logic tc_d = g_return ?
      (cfg_q.tc_disable_select != sgss_pkg::TC_DIS_RETURN) :
      (cfg_q.tc_disable_select != sgss_pkg::TC_DIS_SWITCH);

   // selected set only changes on the control tick
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         gain_q <= sgss_pkg::GAIN_BEFORE;
         tc_q <= 1'b1;
         g2sets_q <= 1'b0;
      end
      else if (tick)
      begin
         gain_q <= gain_d;
         if (g_change)
         begin
            tc_q <= tc_d;
         end
         g2sets_q <= sig_sel ? g2_req :
            (gain_d == sgss_pkg::GAIN_AFTER2);
      end
   end

   // history for mode-change and edge decisions
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         mode_prev_q <= sgss_pkg::MODE_POS;
         zsp_prev_q <= 1'b0;
         inp_prev_q <= 1'b0;
      end
      else if (tick)
      begin
         mode_prev_q <= op_mode;
         zsp_prev_q <= flags.zero_speed_flag;
         inp_prev_q <= flags.in_position_flag;
      end
   end

   // fine vibration suppression gate and sequencing
   wire logic fv_allowed = pos_mode &&
      (cfg_q.tuning_mode_select == sgss_pkg::TUNE_MANUAL) &&
      cfg_q.fine_vibration_suppress_enable;
   wire logic inp_rise = flags.in_position_flag && !inp_prev_q;
   wire logic droop_out = flags.droop_over_range &&
      flags.motor_driving;

   always_comb
   begin
      fv_d = fv_q;
      case (fv_q)
         sgss_pkg::FV_IDLE:
         begin
            if (fv_allowed)
            begin
               fv_d = sgss_pkg::FV_ARMED;
            end
         end
         sgss_pkg::FV_ARMED:
         begin
            if (!fv_allowed)
            begin
               fv_d = sgss_pkg::FV_IDLE;
            end
            else if (inp_rise && !droop_out)
            begin
               fv_d = sgss_pkg::FV_HOLD;
            end
         end
         sgss_pkg::FV_HOLD:
         begin
            if (!fv_allowed)
            begin
               fv_d = sgss_pkg::FV_IDLE;
            end
            else if (droop_out)
            begin
               fv_d = sgss_pkg::FV_ARMED;
            end
         end
         default:
         begin
            fv_d = sgss_pkg::FV_IDLE;
         end
      endcase
   end

   // arming takes one tick, so an edge already present when the
   // function is first allowed is not taken as a rising edge
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         fv_q <= sgss_pkg::FV_IDLE;
         fine_q <= 1'b0;
      end
      else if (tick)
      begin
         fv_q <= fv_d;
         fine_q <= (fv_d == sgss_pkg::FV_HOLD);
      end
   end

   // register port
   wire logic wr_cfg = reg_wr && (reg_addr == sgss_pkg::ADDR_CFG);
   wire logic wr_w5 = reg_wr && (reg_addr == sgss_pkg::ADDR_WORD5);
   wire logic [31:0] stat_word = {27'h0, fine_q, tc_q,
      g2sets_q, gain_q};
   wire logic [31:0] rd_mux =
      (reg_addr == sgss_pkg::ADDR_CFG) ? {16'h0000, cfg_q} :
      (reg_addr == sgss_pkg::ADDR_WORD5) ? {16'h0000, word5_q} :
      (reg_addr == sgss_pkg::ADDR_STAT) ? stat_word :
      32'h00000000;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         cfg_q <= sgss_pkg::CFG_RST;
         word5_q <= sgss_pkg::WORD5_RST;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         if (wr_cfg)
         begin
            cfg_q <= reg_wdata[15:0];
         end
         if (wr_w5)
         begin
            word5_q <= reg_wdata[15:0];
         end
         rdata_q <= reg_rd ? rd_mux : 32'h00000000;
      end
   end

   assign reg_rdata = rdata_q;
   assign gain_sel = gain_q;
   assign tc_apply = tc_q;
   assign gain2_sets = g2sets_q;
   assign fine_vib_gain = fine_q;

   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   chk_dir_positive: assert property (
      tick && dir_sel && cmd_pos |=> gain_q == sgss_pkg::GAIN_BEFORE)
      else $error("positive command did not pick before set");

   chk_dir_negative: assert property (
      tick && dir_sel && cmd_neg |=> gain_q == sgss_pkg::GAIN_AFTER)
      else $error("negative command did not pick after set");

   chk_zero_hold: assert property (
      tick && dir_sel && pos_mode && cmd_zero &&
      !flags.in_position_flag && !(from_vel && zsp_prev_q)
      |=> $stable(gain_q))
      else $error("zero command without in-position changed set");

   chk_stop_gain2: assert property (
      tick && dir_sel && pos_mode && cmd_zero &&
      flags.in_position_flag
      |=> gain_q == (stop_en ? sgss_pkg::GAIN_AFTER2 : $past(gain_q)))
      else $error("stop switch setting not followed");

   chk_vel_hold: assert property (
      tick && dir_sel && vel_mode && cmd_zero |=> $stable(gain_q))
      else $error("velocity mode zero command changed set");

   chk_vel_return: assert property (
      tick && dir_sel && pos_mode && from_vel && zsp_prev_q &&
      stop_en && cmd_zero |=> gain_q == sgss_pkg::GAIN_AFTER2)
      else $error("return from velocity did not pick set 2");

   chk_signal_gain2: assert property (
      tick && sig_sel && g2_req
      |=> gain_q == sgss_pkg::GAIN_AFTER2 && g2sets_q)
      else $error("gain-2 request not applied");

   chk_tc_switch: assert property (
      tick && g_change && !g_return &&
      cfg_q.tc_disable_select == sgss_pkg::TC_DIS_SWITCH
      |=> !tc_q)
      else $error("time constant used at switching");

   chk_tc_return: assert property (
      tick && g_change && g_return &&
      cfg_q.tc_disable_select == sgss_pkg::TC_DIS_RETURN
      |=> !tc_q)
      else $error("time constant used at return");

   chk_fine_gate: assert property (
      tick && !fv_allowed |=> !fine_q)
      else $error("fine gain active while not allowed");

   chk_fine_rise: assert property (
      tick && fv_q == sgss_pkg::FV_ARMED && fv_allowed && inp_rise &&
      !droop_out |=> fine_q)
      else $error("in-position edge did not start fine gain");

   chk_fine_droop: assert property (
      tick && fine_q && droop_out |=> !fine_q)
      else $error("droop over range kept fine gain");

   chk_tick_only: assert property (
      !tick |=> $stable(gain_q))
      else $error("set select moved outside control tick");

   cov_dir_stop: cover property (
      tick && dir_sel && stop_g2 ##1 gain_q == sgss_pkg::GAIN_AFTER2);
   cov_sig_g2: cover property (tick && sig_sel && g2_req ##1 g2sets_q);
   cov_fine: cover property (fine_q ##1 !fine_q);
   cov_tc_off: cover property (tick && g_change ##1 !tc_q);
endmodule

//--- core/sgss_pkg.sv
/*
 servo gain set selector: shared constants, enums and carrier structs.
 assumes one 25 MHz clock and a control cycle derived from it.
*/
package sgss_pkg;
   // clock and control cycle timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int CTL_PERIOD_NS = 1000;
   localparam int CTL_CYCLES = (CTL_PERIOD_NS + CLK_PERIOD_NS - 1) /
      CLK_PERIOD_NS;

   // register offsets on the plain port
   localparam logic [3:0] ADDR_CFG = 4'h0;
   localparam logic [3:0] ADDR_WORD5 = 4'h4;
   localparam logic [3:0] ADDR_STAT = 4'h8;
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [15:0] WORD5_RST = 16'h0000;

   // field codes
   localparam logic [3:0] GSRC_SPEED = 4'h4;
   localparam logic [3:0] GSRC_DIR = 4'h5;
   localparam logic [3:0] G2SRC_SIGNAL = 4'h1;
   localparam logic [3:0] G2SRC_SAME = 4'h2;
   localparam logic [3:0] TUNE_MANUAL = 4'h3;
   localparam logic [1:0] TC_DIS_SWITCH = 2'h1;
   localparam logic [1:0] TC_DIS_RETURN = 2'h2;
   localparam int WORD5_G2_BIT = 4;

   typedef enum logic [1:0] {
      GAIN_BEFORE = 2'h0,
      GAIN_AFTER = 2'h1,
      GAIN_AFTER2 = 2'h2
   } sgss_gain_t;

   typedef enum logic [1:0] {
      MODE_POS = 2'h0,
      MODE_PSN = 2'h1,
      MODE_VEL = 2'h2
   } sgss_mode_t;

   typedef enum logic [2:0] {
      FV_IDLE = 3'b001,
      FV_ARMED = 3'b010,
      FV_HOLD = 3'b100
   } sgss_fv_state_t;

   // configuration word, bit 15 down to bit 0
   typedef struct packed {
      logic [3:0] gain_switch_source_select;
      logic [3:0] gain2_source_select;
      logic stop_gain2_switch_select;
      logic [1:0] tc_disable_select;
      logic [3:0] tuning_mode_select;
      logic fine_vibration_suppress_enable;
   } sgss_cfg_t;

   typedef struct packed {
      logic in_position_flag;
      logic zero_speed_flag;
      logic speed_cond_met;
      logic droop_over_range;
      logic motor_driving;
   } sgss_flags_t;
endpackage

//--- core/sgss_tick_div.sv
/*
 control cycle divider: one-cycle tick every DIV clocks.
 assumes a synchronous active-high reset on ref_clk.
*/
`timescale 1ns/10ps
module sgss_tick_div #(
   parameter int DIV = sgss_pkg::CTL_CYCLES
) (
   input wire logic ref_clk,
   input wire logic srst,
   output logic tick
);
   logic [15:0] cnt_q;
   logic tick_q;
   wire logic wrap = (cnt_q == 16'(DIV - 1));

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         cnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end
      else
      begin
         cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
         tick_q <= wrap;
      end
   end

   assign tick = tick_q;
endmodule

//--- core/sgss_sync2.sv
/*
 two flip-flop synchroniser for pin levels.
 assumes inputs are slow levels from outside the clock domain.
*/
`timescale 1ns/10ps
module sgss_sync2 #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;
endmodule

//--- testbench/sgss_ctrl_model.sv
/*
 motion controller model: registers the bench's command settings and
 presents them on the selector's command and status inputs.
 assumes the bench changes its settings right after a rising edge.
*/
`timescale 1ns/10ps
module sgss_ctrl_model #(
   parameter int CMD_W = 16
) (
   input wire logic ref_clk,
   input wire logic [1:0] mode_s,
   input wire logic signed [CMD_W-1:0] cmd_s,
   input wire logic signed [CMD_W-1:0] spd_s,
   input wire logic [4:0] flg_s,
   input wire logic pin_s,
   output logic [1:0] op_mode,
   output logic signed [CMD_W-1:0] cmd_pulse_freq,
   output logic signed [CMD_W-1:0] speed_cmd,
   output sgss_pkg::sgss_flags_t flags,
   output logic gain2_request_input
);
   // outputs are unknown until the first edge, which falls inside reset
   // ccw travel is sent as a positive rate
   always_ff @(posedge ref_clk)
   begin
      op_mode <= mode_s;
      cmd_pulse_freq <= cmd_s;
      speed_cmd <= spd_s;
      flags <= flg_s;
      gain2_request_input <= pin_s;
   end
endmodule

//--- testbench/servo_gain_set_selector_tb.sv
/*
 self-checking bench for the gain set selector: register port tasks,
 command scenarios through the controller model, output comparisons.
 assumes a short control cycle of 4 clocks set by parameter.
*/
`timescale 1ns/10ps
module servo_gain_set_selector_tb;
   localparam int DIV = 4;
   logic ref_clk, srst, reg_wr, reg_rd, pin_s;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd;
   logic [1:0] mode_s, op_mode, gain_sel;
   logic signed [15:0] cmd_s, spd_s, cmd_pulse_freq, speed_cmd;
   logic [4:0] flg_s;
   sgss_pkg::sgss_flags_t flags;
   logic gain2_request_input, tc_apply, gain2_sets, fine_vib_gain;
   int miscompares = 0, compares = 0, cycles = 0, i;
   sgss_top #(.CMD_W(16), .CTL_DIV(DIV)) DUT (.ref_clk(ref_clk),
      .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .op_mode(op_mode), .cmd_pulse_freq(cmd_pulse_freq),
      .speed_cmd(speed_cmd), .flags(flags),
      .gain2_request_input(gain2_request_input), .gain_sel(gain_sel),
      .tc_apply(tc_apply), .gain2_sets(gain2_sets),
      .fine_vib_gain(fine_vib_gain));
   sgss_ctrl_model #(.CMD_W(16)) ctrl (.ref_clk(ref_clk), .mode_s(mode_s),
      .cmd_s(cmd_s), .spd_s(spd_s), .flg_s(flg_s), .pin_s(pin_s),
      .op_mode(op_mode), .cmd_pulse_freq(cmd_pulse_freq),
      .speed_cmd(speed_cmd), .flags(flags),
      .gain2_request_input(gain2_request_input));
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic final_report();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ceiling far above the few hundred cycles the tests need
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         final_report();
      end
   end
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic reg_write(logic [3:0] a, logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   function automatic logic [31:0] mk_cfg(logic [3:0] gs, logic [3:0] g2,
      logic st, logic [1:0] tc, logic [3:0] tu, logic en);
      mk_cfg = {16'h0000, gs, g2, st, tc, tu, en};
   endfunction
   task automatic drive(logic [1:0] m, logic [15:0] c, logic [15:0] s,
      logic [4:0] f, logic p);
      @(posedge ref_clk);
      mode_s <= m;
      cmd_s <= c;
      spd_s <= s;
      flg_s <= f;
      pin_s <= p;
   endtask
   // model, synchroniser and tick phase all fit inside this wait
   task automatic settle();
      repeat (3 * DIV + 4) @(posedge ref_clk);
      #1;
   endtask
   task automatic expect_gain(logic [1:0] g);
      settle();
      chk("gain_sel", {30'h0, gain_sel}, {30'h0, g});
      reg_read(sgss_pkg::ADDR_STAT, rd);
      chk("stat gain", {30'h0, rd[1:0]}, {30'h0, g});
   endtask
   initial
   begin
      srst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      mode_s = 2'h0;
      cmd_s = 16'h0;
      spd_s = 16'h0;
      flg_s = 5'h00;
      pin_s = 1'b0;
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      #1;
      chk("reset out", {gain_sel, tc_apply, gain2_sets, fine_vib_gain},
         {2'h0, 3'h4});
      reg_write(4'hC, 32'h0000FFFF);
      reg_read(sgss_pkg::ADDR_CFG, rd);
      chk("cfg reset", rd, {16'h0, sgss_pkg::CFG_RST});
      reg_read(sgss_pkg::ADDR_WORD5, rd);
      chk("word5 reset", rd, {16'h0, sgss_pkg::WORD5_RST});
      reg_read(4'hC, rd);
      chk("unmapped", rd, 32'h0);
      $display("test reset done");
      reg_write(sgss_pkg::ADDR_CFG, mk_cfg(4'h5, 4'h2, 1'b0,
         sgss_pkg::TC_DIS_SWITCH, 4'h0, 1'b0));
      drive(2'h0, 16'hFFFB, 16'h0, 5'h00, 1'b0);
      expect_gain(sgss_pkg::GAIN_AFTER);
      chk("tc switch", tc_apply, 1'b0);
      drive(2'h0, 16'h0005, 16'h0, 5'h00, 1'b0);
      expect_gain(sgss_pkg::GAIN_BEFORE);
      chk("tc return", tc_apply, 1'b1);
      reg_write(sgss_pkg::ADDR_CFG, mk_cfg(4'h5, 4'h2, 1'b0,
         sgss_pkg::TC_DIS_RETURN, 4'h0, 1'b0));
      drive(2'h0, 16'hFFFB, 16'h0, 5'h00, 1'b0);
      expect_gain(sgss_pkg::GAIN_AFTER);
      chk("tc switch", tc_apply, 1'b1);
      drive(2'h0, 16'h0005, 16'h0, 5'h00, 1'b0);
      expect_gain(sgss_pkg::GAIN_BEFORE);
      chk("tc return", tc_apply, 1'b0);
      $display("test direction done");
      drive(2'h0, 16'hFFFB, 16'h0, 5'h00, 1'b0);
      expect_gain(sgss_pkg::GAIN_AFTER);
      reg_write(sgss_pkg::ADDR_CFG, mk_cfg(4'h5, 4'h2, 1'b1, 2'h0, 4'h0,
         1'b0));
      drive(2'h0, 16'h0000, 16'h0, 5'h00, 1'b0);
      expect_gain(sgss_pkg::GAIN_AFTER);
      reg_write(sgss_pkg::ADDR_CFG, mk_cfg(4'h5, 4'h2, 1'b0, 2'h0, 4'h0,
         1'b0));
      drive(2'h0, 16'h0000, 16'h0, 5'h10, 1'b0);
      expect_gain(sgss_pkg::GAIN_AFTER);
      reg_write(sgss_pkg::ADDR_CFG, mk_cfg(4'h5, 4'h2, 1'b1, 2'h0, 4'h0,
         1'b0));
      expect_gain(sgss_pkg::GAIN_AFTER2);
      drive(2'h2, 16'h0000, 16'h0, 5'h10, 1'b0);
      expect_gain(sgss_pkg::GAIN_AFTER2);
      drive(2'h2, 16'hFFFB, 16'h0005, 5'h00, 1'b0);
      expect_gain(sgss_pkg::GAIN_BEFORE);
      drive(2'h2, 16'h0000, 16'h0, 5'h18, 1'b0);
      expect_gain(sgss_pkg::GAIN_BEFORE);
      drive(2'h0, 16'h0000, 16'h0, 5'h08, 1'b0);
      expect_gain(sgss_pkg::GAIN_AFTER2);
      $display("test stop done");
      reg_write(sgss_pkg::ADDR_CFG, mk_cfg(4'h4, 4'h1, 1'b0, 2'h0, 4'h0,
         1'b0));
      drive(2'h0, 16'h0000, 16'h0, 5'h00, 1'b0);
      reg_write(sgss_pkg::ADDR_WORD5, 32'h1 << sgss_pkg::WORD5_G2_BIT);
      expect_gain(sgss_pkg::GAIN_AFTER2);
      chk("g2 sets on", gain2_sets, 1'b1);
      reg_write(sgss_pkg::ADDR_WORD5, 32'h0);
      settle();
      chk("g2 sets off", gain2_sets, 1'b0);
      drive(2'h0, 16'h0000, 16'h0, 5'h00, 1'b1);
      expect_gain(sgss_pkg::GAIN_AFTER2);
      chk("g2 sets pin", gain2_sets, 1'b1);
      drive(2'h0, 16'h0000, 16'h0, 5'h00, 1'b0);
      settle();
      chk("g2 sets pin off", gain2_sets, 1'b0);
      drive(2'h0, 16'h0000, 16'h0, 5'h04, 1'b0);
      expect_gain(sgss_pkg::GAIN_AFTER);
      drive(2'h0, 16'h0000, 16'h0, 5'h04, 1'b1);
      expect_gain(sgss_pkg::GAIN_AFTER2);
      $display("test gain2 done");
      reg_write(sgss_pkg::ADDR_CFG, mk_cfg(4'h0, 4'h0, 1'b0, 2'h0,
         sgss_pkg::TUNE_MANUAL, 1'b1));
      settle();
      drive(2'h0, 16'h0000, 16'h0, 5'h10, 1'b0);
      settle();
      chk("fine on", fine_vib_gain, 1'b1);
      drive(2'h0, 16'h0000, 16'h0, 5'h13, 1'b0);
      settle();
      chk("fine droop", fine_vib_gain, 1'b0);
      // tuning code, enable and mode each block the fine gain in turn
      for (i = 0; i < 3; i++)
      begin
         reg_write(sgss_pkg::ADDR_CFG, mk_cfg(4'h0, 4'h0, 1'b0, 2'h0,
            (i == 0) ? 4'h0 : sgss_pkg::TUNE_MANUAL, i != 1));
         drive((i == 2) ? 2'h2 : 2'h0, 16'h0000, 16'h0, 5'h00, 1'b0);
         settle();
         drive((i == 2) ? 2'h2 : 2'h0, 16'h0000, 16'h0, 5'h10, 1'b0);
         settle();
         chk("fine blocked", fine_vib_gain, 1'b0);
      end
      $display("test fine done");
      final_report();
   end
endmodule
